// *** hdl/vit_consts.svh ***
// Constants for the voltage identification code transmitter
`ifndef VIT_CONSTS_SVH
`define VIT_CONSTS_SVH
`define VIT_CODE_W        6
`define VIT_LINES_W       6
`define VIT_SEL_W         2
`define VIT_SEL_PARALLEL  2'h0
`define VIT_SEL_TWO_PHASE 2'h1
`define VIT_STROBE_BIT    5
`define VIT_DATA_LSB      2
`define VIT_CLK_PERIOD_NS 10
`define VIT_PHASE_NS      1000
`define VIT_PHASE_CYC     ((`VIT_PHASE_NS + `VIT_CLK_PERIOD_NS - 1) / `VIT_CLK_PERIOD_NS)
`define VIT_CNT_W         16
`endif

// *** hdl/vit_pkg.sv ***
// Types for the voltage identification code transmitter
`include "vit_consts.svh"
package vit_pkg;
	typedef enum logic [2:0] {
		VIT_ST_RESET  = 3'b000,
		VIT_ST_PAR    = 3'b001,
		VIT_ST_LOW    = 3'b010,
		VIT_ST_HIGH   = 3'b011,
		VIT_ST_DONE   = 3'b100,
		VIT_ST_HOLD   = 3'b101
	} vit_state_t;

	typedef struct packed {
		logic [`VIT_LINES_W-1:0] out;
		logic [`VIT_LINES_W-1:0] oe;
	} vit_lines_t;
endpackage

// *** hdl/vit_transmitter.sv ***
// Voltage identification code transmitter over open-drain control lines
`timescale 1ns/1ps
`include "vit_consts.svh"
module vit_transmitter #(
	parameter int unsigned PHASE_CYC = `VIT_PHASE_CYC
) (
	input  wire logic                          I_CLK,
	input  wire logic                          I_RST_N,
	input  wire logic [`VIT_CODE_W-1:0]        I_VOLTAGE_IDENT_CODE,
	input  wire logic [`VIT_SEL_W-1:0]         I_CODE_INTERFACE_SELECT,
	input  wire logic [`VIT_LINES_W-1:0]       I_VOLTAGE_CONTROL_LINES,
	output logic      [`VIT_LINES_W-1:0]       O_VOLTAGE_CONTROL_LINES,
	output logic      [`VIT_LINES_W-1:0]       O_VOLTAGE_CONTROL_LINES_OE,
	output logic                               O_TRANSFER_DONE,
	output logic                               O_SELECT_INVALID
);
	import vit_pkg::*;

	// Select pins come from straps off chip, so synchronise first
	logic [`VIT_SEL_W-1:0]  sel_m_q;
	logic [`VIT_SEL_W-1:0]  sel_s_q;
	vit_state_t             state_q;
	vit_state_t             state_d;
	logic [`VIT_CNT_W-1:0]  cnt_q;
	logic [`VIT_CNT_W-1:0]  cnt_d;
	logic [`VIT_CODE_W-1:0] code_q;
	logic [`VIT_CODE_W-1:0] code_d;
	vit_lines_t             lines_q;
	vit_lines_t             lines_d;
	logic                   done_q;
	logic                   done_d;
	logic                   bad_q;
	logic                   bad_d;
	logic                   unused_in;

	// Line inputs exist only for pin completeness
	assign unused_in = ^I_VOLTAGE_CONTROL_LINES;

	// No reset here: straps must be through both stages by reset release
	always_ff @(posedge I_CLK) begin
		sel_m_q <= I_CODE_INTERFACE_SELECT;
		sel_s_q <= sel_m_q;
	end

	// Open drain: oe high pulls low, so oe is the inverse of the bit
	function automatic vit_lines_t drive(input logic [`VIT_LINES_W-1:0] bits,
		input logic [`VIT_LINES_W-1:0] used);
		vit_lines_t l;
		l.out = `VIT_LINES_W'h0;
		l.oe  = ~bits & used;
		return l;
	endfunction

	localparam logic [`VIT_LINES_W-1:0] ALL_USED = `VIT_LINES_W'h3F;
	localparam logic [`VIT_LINES_W-1:0] TP_USED  = `VIT_LINES_W'h3C;

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		code_d  = code_q;
		lines_d = lines_q;
		done_d  = done_q;
		bad_d   = bad_q;
		unique case (state_q)
			VIT_ST_RESET: begin
				// Wait for the strap synchroniser to fill before deciding
				state_d = VIT_ST_HOLD;
			end
			VIT_ST_HOLD: begin
				code_d = I_VOLTAGE_IDENT_CODE;
				cnt_d  = `VIT_CNT_W'h0;
				if (sel_s_q == `VIT_SEL_PARALLEL) begin
					state_d = VIT_ST_PAR;
				end else if (sel_s_q == `VIT_SEL_TWO_PHASE) begin
					state_d = VIT_ST_LOW;
				end else begin
					// Reserved strap: stay released and flag it
					bad_d   = 1'b1;
					state_d = VIT_ST_DONE;
				end
			end
			VIT_ST_PAR: begin
				lines_d = drive(code_q, ALL_USED);
				done_d  = 1'b1;
				state_d = VIT_ST_DONE;
			end
			VIT_ST_LOW: begin
				lines_d = drive({1'b0, code_q[2:0], 2'b11}, TP_USED);
				cnt_d   = cnt_q + `VIT_CNT_W'h1;
				if (cnt_q == PHASE_CYC[`VIT_CNT_W-1:0] - `VIT_CNT_W'h1) begin
					cnt_d   = `VIT_CNT_W'h0;
					state_d = VIT_ST_HIGH;
				end
			end
			VIT_ST_HIGH: begin
				lines_d = drive({1'b1, code_q[5:3], 2'b11}, TP_USED);
				done_d  = 1'b1;
				state_d = VIT_ST_DONE;
			end
			VIT_ST_DONE: begin
				// Terminal until next reset, so the transfer never repeats
				state_d = VIT_ST_DONE;
			end
			default: state_d = VIT_ST_RESET;
		endcase
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			state_q <= VIT_ST_RESET;
			cnt_q   <= `VIT_CNT_W'h0;
			code_q  <= `VIT_CODE_W'h0;
			lines_q <= '0;
			done_q  <= 1'b0;
			bad_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			code_q  <= code_d;
			lines_q <= lines_d;
			done_q  <= done_d;
			bad_q   <= bad_d;
		end
	end

	assign O_VOLTAGE_CONTROL_LINES    = lines_q.out;
	assign O_VOLTAGE_CONTROL_LINES_OE = lines_q.oe;
	assign O_TRANSFER_DONE            = done_q;
	assign O_SELECT_INVALID           = bad_q;

	a_reset_released: assert property (@(posedge I_CLK)
		!I_RST_N |=> (lines_q.oe == '0))
		else $error("lines driven after reset");

	a_open_drain_out: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		lines_q.out == '0)
		else $error("open drain line driven high");

	a_parallel_code: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(state_q == VIT_ST_PAR) |=> (lines_q.oe == ~code_q) && done_q)
		else $error("parallel code wrong");

	a_parallel_together: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(state_q == VIT_ST_PAR) |=> ($past(lines_q.oe) == '0) ##1 $stable(lines_q.oe))
		else $error("parallel lines did not switch together");

	a_reset_flags: assert property (@(posedge I_CLK)
		!I_RST_N |=> !done_q && !bad_q)
		else $error("status flags set after reset");

	a_hold_capture: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(state_q == VIT_ST_HOLD) |=> code_q == $past(I_VOLTAGE_IDENT_CODE))
		else $error("code not captured");

	a_invalid_release: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		bad_q |-> (lines_q.oe == '0) && !done_q)
		else $error("reserved strap drove lines");

	a_done_sticky: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		done_q |=> done_q)
		else $error("done flag dropped");

	// Checker helper: cycles for which the strobe line has been pulled low
	logic [`VIT_CNT_W-1:0] chk_low_q;
	logic [`VIT_CNT_W-1:0] chk_low_d;

	always_comb begin
		chk_low_d = chk_low_q + `VIT_CNT_W'h1;
		if (!lines_q.oe[`VIT_STROBE_BIT]) begin
			chk_low_d = `VIT_CNT_W'h0;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			chk_low_q <= `VIT_CNT_W'h0;
		end else begin
			chk_low_q <= chk_low_d;
		end
	end

	a_low_phase_len: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		$fell(lines_q.oe[`VIT_STROBE_BIT]) |-> chk_low_q == PHASE_CYC[`VIT_CNT_W-1:0])
		else $error("low phase length wrong");

	sequence s_low_phase;
		(state_q == VIT_ST_LOW) ##1 lines_q.oe[`VIT_STROBE_BIT];
	endsequence

	a_strobe_low: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		s_low_phase |-> lines_q.oe[4:2] == ~code_q[2:0])
		else $error("low phase data wrong");

	a_strobe_high: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(state_q == VIT_ST_HIGH) |=> !lines_q.oe[`VIT_STROBE_BIT]
		&& lines_q.oe[4:2] == ~code_q[5:3])
		else $error("high phase data wrong");

	a_unused_lines: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(sel_s_q == `VIT_SEL_TWO_PHASE && state_q != VIT_ST_PAR) |-> lines_q.oe[1:0] == 2'b00)
		else $error("unused lines pulled");

	a_once_only: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(state_q == VIT_ST_DONE) |=> (state_q == VIT_ST_DONE) && $stable(lines_q))
		else $error("transfer repeated");

	a_select_mode: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(state_q == VIT_ST_HOLD && sel_s_q == `VIT_SEL_TWO_PHASE) |=> state_q == VIT_ST_LOW)
		else $error("mode select ignored");
endmodule

// *** testbench/vit_rx_model.sv ***
// Four-input code receiver model sitting on the voltage control lines
`timescale 1ns/1ps
module vit_rx_model (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic [5:0] i_lines,
	output logic      [5:0] o_code,
	output int              o_edges,
	output int              o_mv
);
	logic strobe_q;
	int   wait_q;

	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_code   <= 6'h2F;
			o_edges  <= 0;
			o_mv     <= 1000;
			// Idle level of a released line, so release gives no false edge
			strobe_q <= 1'b1;
			wait_q   <= 0;
		end else begin
			strobe_q <= i_lines[5];
			if (i_lines[5] !== strobe_q) begin
				// Settle first; an edge-latching receiver would be too kind
				o_edges <= o_edges + 1;
				wait_q  <= 2;
			end else if (wait_q != 0) begin
				wait_q <= wait_q - 1;
				if (wait_q == 1 && i_lines[5] == 1'b0)
					o_code[2:0] <= i_lines[4:2];
				else if (wait_q == 1) begin
					o_code[5:3] <= i_lines[4:2];
					o_mv        <= 700 + ({i_lines[4:2], o_code[2:0]} * 403 + 31) / 63;
				end
			end
		end
	end
endmodule

// *** testbench/vit_transmitter_test.sv ***
// Self-checking bench for the voltage identification code transmitter
`timescale 1ns/1ps
module vit_transmitter_test;
	logic       clk             = 1'b0;
	logic       rst_n           = 1'b0;
	logic [5:0] code            = 6'h00;
	logic [1:0] sel             = 2'h0;
	logic [5:0] lines;
	logic [5:0] oe;
	logic [5:0] rx_code;
	logic       done;
	logic       inval;
	int         rx_edges;
	int         rx_mv;
	int         miscompares     = 0;
	int         samples_checked = 0;
	int         seed            = 79;
	int         n;
	logic [5:0] exp;
	wire  [5:0] wire_lv         = ~oe; // Pull-ups make released lines high

	always #5 clk = ~clk;

	vit_transmitter #(.PHASE_CYC(4)) i_dut (
		.I_CLK                      (clk),
		.I_RST_N                    (rst_n),
		.I_VOLTAGE_IDENT_CODE       (code),
		.I_CODE_INTERFACE_SELECT    (sel),
		.I_VOLTAGE_CONTROL_LINES    (wire_lv),
		.O_VOLTAGE_CONTROL_LINES    (lines),
		.O_VOLTAGE_CONTROL_LINES_OE (oe),
		.O_TRANSFER_DONE            (done),
		.O_SELECT_INVALID           (inval)
	);

	vit_rx_model i_rx (
		.i_clk   (clk),
		.i_rst_n (rst_n),
		.i_lines (wire_lv),
		.o_code  (rx_code),
		.o_edges (rx_edges),
		.o_mv    (rx_mv)
	);

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expct);
		samples_checked++;
		if (seen !== expct) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, expct, seen);
		end
	endtask

	task give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		for (int t = 0; t < 8; t++) begin
			@(posedge clk) #1;
			rst_n = 1'b0;
			code  = 6'($random(seed));
			sel   = 2'(t % 4);
			repeat (4) @(posedge clk);
			#1;
			check("reset lines", wire_lv, 8'h3F);
			check("reset done", done, 8'h00);
			check("rx init code", rx_code, 16'h002F);
			check("rx init volt", 16'(rx_mv), 16'h03E8);
			rst_n = 1'b1;
			n = 0;
			while (done !== 1'b1 && inval !== 1'b1 && n < 40) begin
				@(posedge clk) #1;
				n++;
			end
			if (n == 40) begin
				miscompares++;
				give_verdict;
			end
			// Reference: final wire picture per mode, reserved straps stay released
			exp = (sel == 2'h0) ? code : (sel == 2'h1) ? {1'b1, code[5:3], 2'b11} : 6'h3F;
			check("lines", wire_lv, exp);
			check("pin level", lines, 8'h00);
			check("invalid", inval, sel > 2'h1);
			if (sel == 2'h1) begin
				repeat (3) @(posedge clk);
				#1;
				check("rx code", rx_code, code);
				check("rx volt", 16'(rx_mv), 16'(700 + (int'(code) * 403 + 31) / 63));
			end
			code = ~code;
			repeat (12) @(posedge clk);
			#1;
			check("held lines", wire_lv, exp);
			if (sel == 2'h1)
				check("strobe edges", 16'(rx_edges), 8'h02);
		end
		give_verdict;
	end
endmodule
